// >>> common/icil_regs.svh
// register map, reset values and timing counts of the input channel interrupt logic
`ifndef ICIL_REGS_SVH
`define ICIL_REGS_SVH

// byte addresses on the register bus
`define ICIL_OFS_TYPE 8'h00
`define ICIL_OFS_POL 8'h04
`define ICIL_OFS_EN 8'h08
`define ICIL_OFS_STAT 8'h0c
`define ICIL_OFS_MASK 8'h10
`define ICIL_OFS_VEC 8'h14
`define ICIL_OFS_DIN 8'h18

// reset values
`define ICIL_RST_TYPE 8'h00
`define ICIL_RST_POL 8'h00
`define ICIL_RST_EN 8'h00
`define ICIL_RST_STAT 8'h00
`define ICIL_RST_MASK 8'hff
`define ICIL_RST_VEC 8'h00

// field layout
`define ICIL_REG_W 8
`define ICIL_NCH 8
`define ICIL_LANE0 0

// timing: interrupt logic response time
`define ICIL_CLK_PERIOD_NS 50
`define ICIL_RESP_NS 1000
`define ICIL_RESP_CYC ((`ICIL_RESP_NS + `ICIL_CLK_PERIOD_NS - 1) / `ICIL_CLK_PERIOD_NS)

`endif

// >>> common/icil_pkg.sv
// types shared by the input channel interrupt logic
package icil_pkg;

  // gray codes along idle -> drive -> turnaround; both bits change on the step back to idle
  typedef enum logic [1:0] {
    IACK_IDLE = 2'b00,
    IACK_DRIVE = 2'b01,
    IACK_TURN = 2'b11
  } icil_iack_e;

  typedef logic [7:0] icil_byte_t;

endpackage : icil_pkg

// >>> common/icil_det_if.sv
// signals between the register side and the channel detectors
`timescale 1ns/100ps
interface icil_det_if #(
  parameter int NCH = 8
);
  logic [NCH-1:0] sample;
  logic [NCH-1:0] typeSel;
  logic [NCH-1:0] polSel;
  logic [NCH-1:0] chanEn;
  logic [NCH-1:0] evt;

  modport det (
    input sample,
    input typeSel,
    input polSel,
    input chanEn,
    output evt
  );

  modport ctl (
    output sample,
    output typeSel,
    output polSel,
    output chanEn,
    input evt
  );
endinterface : icil_det_if

// >>> rtl/icil_detect.sv
// per-channel condition detectors with response-time holdoff
`timescale 1ns/100ps
`include "icil_regs.svh"
module icil_detect #(
  parameter int NCH = 8,
  parameter int RESP_CYCLES = `ICIL_RESP_CYC
) (
  input wire logic core_clk, // block clock
  input wire logic srst, // synchronous reset, high
  icil_det_if.det det // samples, config and events
);
  localparam int CW = $clog2(RESP_CYCLES + 1);
  localparam logic [CW-1:0] HOLD = CW'(RESP_CYCLES);
  localparam logic [CW-1:0] ZERO = '0;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gCh
      logic prev_q;
      logic prev_d;
      logic [CW-1:0] hold_q;
      logic [CW-1:0] hold_d;
      logic raw;
      logic fire;

      always_comb begin
        // polarity only matters for level channels
        if (det.typeSel[g]) begin
          raw = det.sample[g] ^ prev_q;
        end else begin
          raw = (det.sample[g] == det.polSel[g]);
        end
        fire = raw && det.chanEn[g] && (hold_q == ZERO);
        prev_d = det.sample[g];
        if (fire) begin
          hold_d = HOLD;
        end else if (hold_q != ZERO) begin
          hold_d = hold_q - 1'b1;
        end else begin
          hold_d = hold_q;
        end
      end

      always_ff @(posedge core_clk) begin
        if (srst) begin
          prev_q <= 1'b0;
          hold_q <= ZERO;
        end else begin
          prev_q <= prev_d;
          hold_q <= hold_d;
        end
      end

      assign det.evt[g] = fire;
    end
  endgenerate

endmodule : icil_detect

// >>> rtl/icil_top.sv
// input channel interrupt logic: register file, detectors and interrupt select answer
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
`include "icil_regs.svh"
module icil_top #(
  parameter int NCH = `ICIL_NCH,
  parameter int ADDR_W = 8,
  parameter int RESP_CYCLES = `ICIL_RESP_CYC
) (
  input wire logic core_clk, // 20 MHz block clock
  input wire logic srst, // synchronous reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high = write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data, registered
  output logic pslverr, // apb error on unmapped address
  input wire logic [NCH-1:0] chanIn, // digital input channels
  input wire logic intSelN, // interrupt select strobe, low
  input wire logic addrA1, // request select, low = request 0
  output logic ackN, // bus acknowledge, low
  output logic [7:0] dataOut, // vector onto low data lines
  output logic dataOeN, // data output enable, low while driving
  output logic intReq0N, // interrupt request 0, low
  output logic intReq1N, // interrupt request 1, never asserted
  output logic irq // level interrupt, high while unmasked flag set
);
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam int PADW = 32 - NCH;

  // ---------------------------------------------------------------- input sampling
  logic [NCH-1:0] sample_q;
  logic [NCH-1:0] sample_d;

  always_comb begin
    sample_d = chanIn;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sample_q <= '0;
    end else begin
      sample_q <= sample_d;
    end
  end

  // ---------------------------------------------------------------- apb handshake
  // one wait state so that read data can leave a flip-flop
  logic ready_q;
  logic ready_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic slverr_q;
  logic slverr_d;
  logic access;
  logic commit;
  logic wrCommit;
  logic lane0;
  logic hit;
  logic [31:0] rdMux;

  assign access = psel && penable;
  assign commit = access && ready_q;
  assign wrCommit = commit && pwrite;
  assign lane0 = pstrb[`ICIL_LANE0];

  // ---------------------------------------------------------------- registers
  logic [NCH-1:0] type_q;
  logic [NCH-1:0] type_d;
  logic [NCH-1:0] pol_q;
  logic [NCH-1:0] pol_d;
  logic [NCH-1:0] en_q;
  logic [NCH-1:0] en_d;
  logic [NCH-1:0] stat_q;
  logic [NCH-1:0] stat_d;
  logic [NCH-1:0] mask_q;
  logic [NCH-1:0] mask_d;
  logic [7:0] vec_q;
  logic [7:0] vec_d;
  logic [NCH-1:0] wByte;
  logic [NCH-1:0] clrBits;
  logic [NCH-1:0] evt;

  assign wByte = pwdata[NCH-1:0];

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      ADDR_W'(`ICIL_OFS_TYPE): rdMux = {PADW'(0), type_q};
      ADDR_W'(`ICIL_OFS_POL): rdMux = {PADW'(0), pol_q};
      ADDR_W'(`ICIL_OFS_EN): rdMux = {PADW'(0), en_q};
      ADDR_W'(`ICIL_OFS_STAT): rdMux = {PADW'(0), stat_q};
      ADDR_W'(`ICIL_OFS_MASK): rdMux = {PADW'(0), mask_q};
      ADDR_W'(`ICIL_OFS_VEC): rdMux = {24'h00_0000, vec_q};
      ADDR_W'(`ICIL_OFS_DIN): rdMux = {PADW'(0), sample_q};
      default: begin
        rdMux = ZERO32;
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    ready_d = access && !ready_q;
    rdata_d = rdata_q;
    slverr_d = 1'b0;
    if (access && !ready_q) begin
      rdata_d = pwrite ? ZERO32 : rdMux;
      slverr_d = !hit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ready_q <= 1'b0;
      rdata_q <= ZERO32;
      slverr_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign pready = ready_q;
  assign prdata = rdata_q;
  assign pslverr = slverr_q;

  // configuration writes take effect only at the edge the access completes
  always_comb begin
    type_d = type_q;
    pol_d = pol_q;
    en_d = en_q;
    mask_d = mask_q;
    vec_d = vec_q;
    clrBits = '0;
    if (wrCommit && lane0) begin
      unique case (paddr)
        ADDR_W'(`ICIL_OFS_TYPE): type_d = wByte;
        ADDR_W'(`ICIL_OFS_POL): pol_d = wByte;
        ADDR_W'(`ICIL_OFS_EN): en_d = wByte;
        ADDR_W'(`ICIL_OFS_STAT): clrBits = wByte;
        ADDR_W'(`ICIL_OFS_MASK): mask_d = wByte;
        ADDR_W'(`ICIL_OFS_VEC): vec_d = pwdata[7:0];
        default: begin
          type_d = type_q;
        end
      endcase
    end
    // a new event in the clearing cycle survives the clear
    stat_d = (stat_q & ~clrBits) | evt;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      type_q <= NCH'(`ICIL_RST_TYPE);
      pol_q <= NCH'(`ICIL_RST_POL);
      en_q <= NCH'(`ICIL_RST_EN);
      stat_q <= NCH'(`ICIL_RST_STAT);
      mask_q <= NCH'(`ICIL_RST_MASK);
      vec_q <= `ICIL_RST_VEC;
    end else begin
      type_q <= type_d;
      pol_q <= pol_d;
      en_q <= en_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      vec_q <= vec_d;
    end
  end

  // ---------------------------------------------------------------- detectors
  icil_det_if #(.NCH(NCH)) detBus ();

  assign detBus.sample = sample_q;
  assign detBus.typeSel = type_q;
  assign detBus.polSel = pol_q;
  assign detBus.chanEn = en_q;
  assign evt = detBus.evt;

  icil_detect #(
    .NCH(NCH),
    .RESP_CYCLES(RESP_CYCLES)
  ) uDetect (
    .core_clk(core_clk),
    .srst(srst),
    .det(detBus)
  );

  // ---------------------------------------------------------------- request lines
  // request is registered from the next flags and mask: it drops at the same edge the last flag is cleared
  logic irq_q;
  logic irq_d;

  always_comb begin
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;
  assign intReq0N = !irq_q;
  assign intReq1N = 1'b1;

  // ---------------------------------------------------------------- interrupt select answer
  // request 1 is never raised, so a select with A1 high gets no answer
  icil_pkg::icil_iack_e iack_q;
  icil_pkg::icil_iack_e iack_d;
  icil_pkg::icil_byte_t dout_q;
  icil_pkg::icil_byte_t dout_d;
  logic oeN_q;
  logic oeN_d;
  logic ackN_q;
  logic ackN_d;

  always_comb begin
    iack_d = iack_q;
    dout_d = dout_q;
    oeN_d = 1'b1;
    ackN_d = 1'b1;
    unique case (iack_q)
      icil_pkg::IACK_IDLE: begin
        if (!intSelN && !addrA1) begin
          iack_d = icil_pkg::IACK_DRIVE;
          dout_d = vec_q;
          oeN_d = 1'b0;
          ackN_d = 1'b0;
        end
      end
      icil_pkg::IACK_DRIVE: begin
        if (intSelN) begin
          iack_d = icil_pkg::IACK_TURN;
        end else begin
          oeN_d = 1'b0;
          ackN_d = 1'b0;
        end
      end
      icil_pkg::IACK_TURN: begin
        iack_d = icil_pkg::IACK_IDLE;
        dout_d = 8'h00;
      end
      default: begin
        iack_d = icil_pkg::IACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      iack_q <= icil_pkg::IACK_IDLE;
      dout_q <= 8'h00;
      oeN_q <= 1'b1;
      ackN_q <= 1'b1;
    end else begin
      iack_q <= iack_d;
      dout_q <= dout_d;
      oeN_q <= oeN_d;
      ackN_q <= ackN_d;
    end
  end

  assign dataOut = dout_q;
  assign dataOeN = oeN_q;
  assign ackN = ackN_q;

endmodule : icil_top

// >>> test/icil_top_asserts.sv
// port-level assertions for the input channel interrupt logic
`timescale 1ns/100ps
module icil_top_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk, // clock
  input wire logic srst, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic intSelN, // select strobe
  input wire logic addrA1, // request select
  input wire logic ackN, // acknowledge
  input wire logic dataOeN, // vector drive
  input wire logic intReq0N, // request 0
  input wire logic intReq1N, // request 1
  input wire logic irq // level interrupt
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_req1_idle: assert property (intReq1N) else $error("request 1 asserted");
  a_req0_level: assert property (intReq0N == !irq) else $error("request 0 off irq");
  a_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready timing wrong");
  a_err_unmapped: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h18))
    else $error("error flag wrong");
  a_ack_answer: assert property ($fell(intSelN) && !addrA1 |=> !ackN && !dataOeN)
    else $error("select not answered");
  a_a1_refused: assert property (!intSelN && addrA1 && ackN |=> ackN && dataOeN)
    else $error("answered request 1");
  a_ack_release: assert property (!ackN && intSelN |=> ackN && dataOeN)
    else $error("acknowledge held");
  // a request may only drop after a status or mask write completes
  a_irq_hold: assert property ($fell(irq) |-> $past(pready && pwrite && paddr[4:2] inside {3, 4}))
    else $error("irq dropped unprompted");
endmodule : icil_top_asserts

bind icil_top icil_top_asserts #(.ADDR_W(ADDR_W)) u_icil_top_asserts (.core_clk(core_clk),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .intSelN(intSelN), .addrA1(addrA1), .ackN(ackN),
  .dataOeN(dataOeN), .intReq0N(intReq0N), .intReq1N(intReq1N), .irq(irq));

// >>> test/icil_carrier_model.sv
// carrier side of the interrupt select handshake
`timescale 1ns/100ps
module icil_carrier_model (
  input wire logic core_clk, // clock
  output logic intSelN = 1'b1, // select strobe, low
  output logic addrA1 = 1'b0, // request select
  input wire logic ackN, // acknowledge, low
  input wire logic [7:0] dataOut // vector lines
);
  // a refused select is dropped after six cycles, like a carrier bus timeout
  task automatic select(input logic a1, output logic [7:0] vec, output logic acked);
    acked = 1'b0;
    vec = 8'h00;
    @(posedge core_clk);
    intSelN <= 1'b0;
    addrA1 <= a1;
    for (int n = 0; n < 6 && !acked; n++) begin
      @(posedge core_clk);
      acked = (ackN === 1'b0);
      vec = dataOut;
    end
    intSelN <= 1'b1;
    addrA1 <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : select
endmodule : icil_carrier_model

// >>> test/input_channel_interrupt_logic_test.sv
// self-checking bench for the input channel interrupt logic
`timescale 1ns/100ps
module input_channel_interrupt_logic_test;
  localparam int RESP = 3;
  typedef struct {
    logic [7:0] a;
    logic [7:0] rv;
    logic [7:0] wd;
    logic [7:0] ev;
    logic er;
  } icil_row_s;
  icil_row_s rows[7];
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] chanIn = 8'h00;
  logic [3:0] pstrb = 4'h1;
  logic [31:0] prdata, rd;
  logic [7:0] dataOut, vec;
  logic pready, pslverr, intSelN, addrA1, ackN, dataOeN, intReq0N, intReq1N, irq, acked, er;
  int n_errors = 0;
  int n_checks = 0;
  int n_cyc = 0;

  icil_top #(.RESP_CYCLES(RESP)) u_icil_top (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .chanIn(chanIn), .intSelN(intSelN),
    .addrA1(addrA1), .ackN(ackN), .dataOut(dataOut), .dataOeN(dataOeN),
    .intReq0N(intReq0N), .intReq1N(intReq1N), .irq(irq));
  icil_carrier_model u_icil_carrier_model (.core_clk(core_clk), .intSelN(intSelN),
    .addrA1(addrA1), .ackN(ackN), .dataOut(dataOut));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    n_cyc++;
    if (n_cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rc

  initial begin
    rows = '{'{8'h00, 8'h00, 8'h5a, 8'h5a, 1'b0}, '{8'h04, 8'h00, 8'h3c, 8'h3c, 1'b0},
      '{8'h08, 8'h00, 8'h81, 8'h81, 1'b0}, '{8'h10, 8'hff, 8'h0f, 8'h0f, 1'b0},
      '{8'h14, 8'h00, 8'ha5, 8'ha5, 1'b0}, '{8'h18, 8'h00, 8'hff, 8'h00, 1'b0},
      '{8'h1c, 8'h00, 8'h77, 8'h00, 1'b1}};
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rc(8'h0c, 8'h00);
    foreach (rows[i]) rc(rows[i].a, rows[i].rv);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      chk(er, rows[i].er);
      rc(rows[i].a, rows[i].ev);
    end
    // toggle channel 0, polarity set to match the idle low input
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h10, 8'hff);
    apb(1'b1, 8'h08, 8'h01);
    apb(1'b1, 8'h0c, 8'hff);
    repeat (RESP + 3) @(posedge core_clk);
    rc(8'h0c, 8'h00);
    chanIn <= 8'h01;
    @(posedge core_clk);
    chanIn <= 8'h00;
    repeat (RESP + 3) @(posedge core_clk);
    rc(8'h0c, 8'h01);
    chk(intReq0N, 1'b0);
    chk(intReq1N, 1'b1);
    u_icil_carrier_model.select(1'b0, vec, acked);
    chk({acked, vec}, 9'h1a5);
    u_icil_carrier_model.select(1'b1, vec, acked);
    chk(acked, 1'b0);
    apb(1'b1, 8'h0c, 8'h00);
    rc(8'h0c, 8'h01);
    apb(1'b1, 8'h0c, 8'h01);
    rc(8'h0c, 8'h00);
    chk(intReq0N, 1'b1);
    // level: ch1 low/pol 0, ch2 high/pol 1, ch3 high/pol 0, ch4 disabled
    chanIn <= 8'h0c;
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h04, 8'h04);
    apb(1'b1, 8'h08, 8'h0e);
    apb(1'b1, 8'h0c, 8'hff);
    repeat (RESP + 4) @(posedge core_clk);
    rc(8'h0c, 8'h06);
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h0c, 8'h06);
    rc(8'h0c, 8'h00);
    apb(1'b1, 8'h08, 8'h0e);
    repeat (RESP + 4) @(posedge core_clk);
    rc(8'h0c, 8'h06);
    apb(1'b1, 8'h10, 8'h00);
    // irq is registered off the committing edge, so look one edge later
    @(posedge core_clk);
    chk({irq, intReq0N}, 2'b01);
    apb(1'b1, 8'h10, 8'hff);
    @(posedge core_clk);
    chk({irq, intReq0N}, 2'b10);
    // a write with its low byte lane off must leave the vector alone
    pstrb <= 4'h0;
    apb(1'b1, 8'h14, 8'h11);
    pstrb <= 4'h1;
    rc(8'h14, 8'ha5);
    summarize();
  end
endmodule : input_channel_interrupt_logic_test
